// ===== hdl/fcr_drive_reg.sv
// One per-drive rate and precompensation register.
// Assumes the caller decodes the index and gives a one-cycle write.
`timescale 1ns/1ps
`include "fcr_map.svh"

module fcr_drive_reg (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             wr_en,
  input  wire fcr_pkg::fcr_byte_t wdata,
  output fcr_pkg::fcr_byte_t    rdata,
  output logic [1:0]            drive_type_bits,
  output logic [1:0]            rate_table_bits,
  output logic                  precomp_disable
);

  fcr_pkg::fcr_byte_t drv_ff;
  fcr_pkg::fcr_byte_t nxt_drv;

  // Read-only bits 2, 5 and 7 never take a written one
  assign nxt_drv = wr_en ? (wdata & `FCR_DRV_WMASK) : drv_ff;

  // Only the hard reset restores the default
  always_ff @(posedge clk) begin
    if (!resetn) begin
      drv_ff <= `FCR_RST_DRV;
    end else begin
      drv_ff <= nxt_drv;
    end
  end

  // Fields straight off the register, live the cycle after a write
  assign rdata           = drv_ff;
  assign drive_type_bits = drv_ff[`FCR_DRV_DT_HI:`FCR_DRV_DT_LO];
  assign rate_table_bits = drv_ff[`FCR_DRV_DRT_HI:`FCR_DRV_DRT_LO];
  assign precomp_disable = drv_ff[`FCR_DRV_PTS];

endmodule : fcr_drive_reg

// ===== hdl/fcr_floppy_config_regs.sv
// Configuration register bank of the floppy logical device: mode,
// option, drive type storage and two per-drive rate registers,
// plus the pin driver, write-protect and density logic they steer.
// Assumes resetn is the combined supply and host bus hard reset,
// held low at least one clk edge, and that cfg_ld_sel is high only
// while configuration mode is on and this logical device is chosen.
//
// How it works
// - Only supply power-on or host bus hard reset restore defaults.
// - Mode bit 0 picks normal or enhanced floppy mode.
// - Mode bit 1 picks burst or non-burst DMA; non-burst by default.
// - Mode bits 3:2 pick interface personality; 11 standard by default.
// - Mode bit 6 picks open-drain or push-pull floppy outputs.
// - Mode bit 7 puts all dedicated floppy output pins in high impedance.
// - Bits 6 and 7 touch only the dedicated floppy pins.
// - Option bit 0 forces write protect while drive 0 or 1 selected.
// - Core write protect ORs forced, external and device-disable terms.
// - Forced write protect also holds on parallel-port routed drives.
// - Option bits 3:2 steer density output; code 10 forces one.
// - Type register stores two-bit types for four drives.
// - Index f3 is read-only and always reads zero.
// - Drive 0 register: type 1:0, rate table 4:3, bits 2,5,7 zero.
// - Per-drive bit 6 set disables write precompensation.
// - Drive 1 register mirrors drive 0 layout for drive 1.
// - Software writes an index, then reads or writes the data port.
`timescale 1ns/1ps
`include "fcr_map.svh"

module fcr_floppy_config_regs (
  input  wire logic                  clk,
  input  wire logic                  resetn,
  // Index and data configuration port
  input  wire logic                  cfg_ld_sel,
  input  wire logic                  cfg_index_wr,
  input  wire logic                  cfg_index_rd,
  input  wire logic                  cfg_data_wr,
  input  wire logic                  cfg_data_rd,
  input  wire fcr_pkg::fcr_byte_t    cfg_wdata,
  output fcr_pkg::fcr_byte_t         cfg_rdata,
  output logic                       cfg_rvalid,
  // Mode controls to the floppy core
  output logic                       enhanced_mode,
  output logic                       burst_dma_en,
  output fcr_pkg::fcr_iface_e        iface_mode,
  output logic                       push_pull_driver,
  output logic                       pins_tristated,
  // Drive type storage and per-drive fields
  output fcr_pkg::fcr_byte_t         drive_type_store,
  output logic [3:0]                 drive_type_bits,
  output logic [3:0]                 rate_table_bits,
  output logic [1:0]                 precomp_disable,
  output logic [1:0]                 sel_drive_type,
  output logic [1:0]                 sel_rate_table,
  output logic                       sel_precomp_disable,
  // Write protect
  input  wire logic                  drive0_select_n,
  input  wire logic                  drive1_select_n,
  input  wire logic                  write_protect_in_n,
  input  wire logic                  dev_disable_wp,
  output logic                       write_protect_core_n,
  output logic                       status_reg_a_wp,
  // Density select
  input  wire logic                  density_core,
  output logic                       density_out,
  // Dedicated floppy output pins
  input  wire logic [`FCR_NPINS-1:0] core_pin_out,
  output logic [`FCR_NPINS-1:0]      fdd_pin_o,
  output logic [`FCR_NPINS-1:0]      fdd_pin_oe_n
);

  // Index hit test, shared by the write and read decoders
  function automatic logic idx_hit(
    input fcr_pkg::fcr_byte_t idx,
    input fcr_pkg::fcr_byte_t target
  );
    idx_hit = (idx == target);
  endfunction : idx_hit

  // Register state
  fcr_pkg::fcr_byte_t index_ff;
  fcr_pkg::fcr_byte_t mode_ff;
  fcr_pkg::fcr_byte_t opt_ff;
  fcr_pkg::fcr_byte_t type_ff;
  fcr_pkg::fcr_byte_t rdata_ff;
  logic               rvalid_ff;

  // Next values
  fcr_pkg::fcr_byte_t nxt_index;
  fcr_pkg::fcr_byte_t nxt_mode;
  fcr_pkg::fcr_byte_t nxt_opt;
  fcr_pkg::fcr_byte_t nxt_type;
  fcr_pkg::fcr_byte_t nxt_rdata;
  logic               nxt_rvalid;

  // Decode wires
  logic               data_wr_ok;
  logic               data_rd_ok;
  logic               hit_mode;
  logic               hit_opt;
  logic               hit_type;
  logic               hit_rsvd;
  logic               wr_mode;
  logic               wr_opt;
  logic               wr_type;
  logic [`FCR_NDRV-1:0] hit_drv;
  logic [`FCR_NDRV-1:0] wr_drv;
  fcr_pkg::fcr_byte_t drv_rd [`FCR_NDRV];
  fcr_pkg::fcr_byte_t drv_idx [`FCR_NDRV];
  fcr_pkg::fcr_byte_t rd_mux;

  // Selection and pin wires
  logic               drv1_active;
  logic               wp_forced;
  logic               wp_active;
  fcr_pkg::fcr_density_e den_code;
  logic               den_forced;

  // Data port only counts while this logical device is selected.
  // An index write in the same cycle as a data access leaves the
  // data access on the old index, which keeps the order obvious.
  assign data_wr_ok = cfg_data_wr & cfg_ld_sel;
  assign data_rd_ok = cfg_data_rd & cfg_ld_sel;

  // Index decode
  assign hit_mode = idx_hit(index_ff, `FCR_IDX_MODE);
  assign hit_opt  = idx_hit(index_ff, `FCR_IDX_OPTION);
  assign hit_type = idx_hit(index_ff, `FCR_IDX_TYPE);
  assign hit_rsvd = idx_hit(index_ff, `FCR_IDX_RSVD);
  assign drv_idx[0] = `FCR_IDX_DRV0;
  assign drv_idx[1] = `FCR_IDX_DRV1;

  // Write strobes; the reserved index has none, so it stays zero
  assign wr_mode = data_wr_ok & hit_mode;
  assign wr_opt  = data_wr_ok & hit_opt;
  assign wr_type = data_wr_ok & hit_type;

  // Index latch follows every index port write
  assign nxt_index = cfg_index_wr ? cfg_wdata : index_ff;

  // Reserved bits are masked so they neither store nor read back
  assign nxt_mode = wr_mode ? (cfg_wdata & `FCR_MODE_WMASK)
                            : mode_ff;
  assign nxt_opt  = wr_opt ? (cfg_wdata & `FCR_OPT_WMASK)
                           : opt_ff;
  assign nxt_type = wr_type ? cfg_wdata : type_ff;

  // Bank registers. No soft reset input exists here on purpose:
  // these settings must survive a soft reset of the controller.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      index_ff <= `FCR_RST_INDEX;
      mode_ff  <= `FCR_RST_MODE;
      opt_ff   <= `FCR_RST_OPTION;
      type_ff  <= `FCR_RST_TYPE;
    end else begin
      index_ff <= nxt_index;
      mode_ff  <= nxt_mode;
      opt_ff   <= nxt_opt;
      type_ff  <= nxt_type;
    end
  end

  // Two per-drive registers from one module; the layout is shared
  genvar d;
  generate
    for (d = 0; d < `FCR_NDRV; d = d + 1) begin : g_drv
      assign hit_drv[d] = idx_hit(index_ff, drv_idx[d]);
      assign wr_drv[d]  = data_wr_ok & hit_drv[d];

      fcr_drive_reg u_drv (
        .clk             (clk),
        .resetn          (resetn),
        .wr_en           (wr_drv[d]),
        .wdata           (cfg_wdata),
        .rdata           (drv_rd[d]),
        .drive_type_bits (drive_type_bits[2*d+1:2*d]),
        .rate_table_bits (rate_table_bits[2*d+1:2*d]),
        .precomp_disable (precomp_disable[d])
      );
    end
  endgenerate

  // Read selection. Unmapped indexes and the reserved slot read zero.
  assign rd_mux = hit_mode   ? mode_ff
                : hit_opt    ? opt_ff
                : hit_type   ? type_ff
                : hit_rsvd   ? `FCR_ZERO
                : hit_drv[0] ? drv_rd[0]
                : hit_drv[1] ? drv_rd[1]
                : `FCR_ZERO;

  // Index reads return the latch; data reads the selected register
  assign nxt_rdata  = cfg_index_rd ? index_ff
                    : data_rd_ok   ? rd_mux
                    : rdata_ff;
  assign nxt_rvalid = cfg_index_rd | data_rd_ok;

  // Read data holds until the next read; valid is a one-cycle pulse
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rdata_ff  <= `FCR_ZERO;
      rvalid_ff <= 1'b0;
    end else begin
      rdata_ff  <= nxt_rdata;
      rvalid_ff <= nxt_rvalid;
    end
  end

  assign cfg_rdata  = rdata_ff;
  assign cfg_rvalid = rvalid_ff;

  // Mode fields go straight from the register, so a write is seen
  // by the core on the cycle after it lands
  assign enhanced_mode = mode_ff[`FCR_MODE_ENH];
  assign burst_dma_en  = ~mode_ff[`FCR_MODE_DMA];
  assign iface_mode    = fcr_pkg::fcr_iface_e'(
                           mode_ff[`FCR_MODE_IF_HI:`FCR_MODE_IF_LO]);
  assign push_pull_driver = mode_ff[`FCR_MODE_PP];
  assign pins_tristated   = mode_ff[`FCR_MODE_TRI];

  // Drive type storage; C and D slots are plain software storage
  assign drive_type_store = type_ff;

  // Per-drive fields for whichever drive is selected. Drive 0 wins
  // when both selects are low, since it is the boot drive.
  assign drv1_active = drive0_select_n & ~drive1_select_n;
  assign sel_drive_type      = drv1_active ? drive_type_bits[3:2]
                                           : drive_type_bits[1:0];
  assign sel_rate_table      = drv1_active ? rate_table_bits[3:2]
                                           : rate_table_bits[1:0];
  assign sel_precomp_disable = drv1_active ? precomp_disable[1]
                                           : precomp_disable[0];

  // Forced write protect needs a selected drive. The selects come
  // from the core, not from a pin set, so a drive routed to the
  // parallel port pins is covered as well.
  assign wp_forced = opt_ff[`FCR_OPT_FWP] &
                     (~drive0_select_n | ~drive1_select_n);

  // Any source of protection protects; status shows the same term
  assign wp_active = wp_forced | ~write_protect_in_n |
                     dev_disable_wp;
  assign write_protect_core_n = ~wp_active;
  assign status_reg_a_wp      = wp_active;

  // Density select: the two normal codes pass the core's level,
  // the two forcing codes override it
  assign den_code = fcr_pkg::fcr_density_e'(
                      opt_ff[`FCR_OPT_DEN_HI:`FCR_OPT_DEN_LO]);
  assign den_forced = (den_code == fcr_pkg::FCR_DEN_ONE) |
                      (den_code == fcr_pkg::FCR_DEN_ZERO);
  assign density_out = den_forced
                     ? (den_code == fcr_pkg::FCR_DEN_ONE)
                     : density_core;

  // Dedicated floppy pins. Open drain pulls low for a zero and lets
  // go for a one; push-pull drives both levels. Tri-state releases
  // every pin. Parallel-port routed floppy signals never pass here,
  // so they keep their own drivers whatever these bits say.
  genvar p;
  generate
    for (p = 0; p < `FCR_NPINS; p = p + 1) begin : g_pin
      assign fdd_pin_o[p] = push_pull_driver & core_pin_out[p];
      assign fdd_pin_oe_n[p] = pins_tristated |
                               (~push_pull_driver &
                                core_pin_out[p]);
    end
  endgenerate

endmodule : fcr_floppy_config_regs

// ===== hdl/fcr_map.svh
// Index map, reset values and field positions of the floppy
// configuration bank. Definitions only; included by bare name.
`ifndef FCR_MAP_SVH
`define FCR_MAP_SVH

// Register indexes on the configuration data port
`define FCR_IDX_MODE    8'hf0
`define FCR_IDX_OPTION  8'hf1
`define FCR_IDX_TYPE    8'hf2
`define FCR_IDX_RSVD    8'hf3
`define FCR_IDX_DRV0    8'hf4
`define FCR_IDX_DRV1    8'hf5

// Hard reset values
`define FCR_RST_MODE    8'h0e
`define FCR_RST_OPTION  8'h00
`define FCR_RST_TYPE    8'hff
`define FCR_RST_DRV     8'h00
`define FCR_RST_INDEX   8'h00
`define FCR_ZERO        8'h00

// Writable bits; everything else is held at zero
`define FCR_MODE_WMASK  8'hcf
`define FCR_OPT_WMASK   8'h0d
`define FCR_DRV_WMASK   8'h5b

// Field positions
`define FCR_MODE_ENH    0
`define FCR_MODE_DMA    1
`define FCR_MODE_IF_LO  2
`define FCR_MODE_IF_HI  3
`define FCR_MODE_PP     6
`define FCR_MODE_TRI    7
`define FCR_OPT_FWP     0
`define FCR_OPT_DEN_LO  2
`define FCR_OPT_DEN_HI  3
`define FCR_DRV_DT_LO   0
`define FCR_DRV_DT_HI   1
`define FCR_DRV_DRT_LO  3
`define FCR_DRV_DRT_HI  4
`define FCR_DRV_PTS     6

// Structure sizes
`define FCR_NPINS       8
`define FCR_NDRV        2

`endif

// ===== hdl/fcr_pkg.sv
// Types shared by the floppy configuration bank.
// Assumes fcr_map.svh holds all numeric positions and indexes.
package fcr_pkg;

  typedef logic [7:0] fcr_byte_t;

  // Controller interface personality
  typedef enum logic [1:0] {
    FCR_IF_COMPAT_B = 2'h0,
    FCR_IF_COMPAT_A = 2'h1,
    FCR_IF_RSVD     = 2'h2,
    FCR_IF_STD      = 2'h3
  } fcr_iface_e;

  // Density select control
  typedef enum logic [1:0] {
    FCR_DEN_NORM   = 2'h0,
    FCR_DEN_NORM_B = 2'h1,
    FCR_DEN_ONE    = 2'h2,
    FCR_DEN_ZERO   = 2'h3
  } fcr_density_e;

endpackage : fcr_pkg

// ===== test/fcr_cfg_assertions.sv
// Port checker for the floppy configuration bank.
// Assumes it is bound onto fcr_floppy_config_regs by port name.
`timescale 1ns/1ps
module fcr_cfg_assertions (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic       cfg_ld_sel,
  input wire logic       cfg_index_rd,
  input wire logic       cfg_data_rd,
  input wire logic       cfg_data_wr,
  input wire logic       cfg_rvalid,
  input wire logic       enhanced_mode,
  input wire logic       burst_dma_en,
  input wire logic       push_pull_driver,
  input wire logic       pins_tristated,
  input wire logic       write_protect_in_n,
  input wire logic       dev_disable_wp,
  input wire logic       write_protect_core_n,
  input wire logic       status_reg_a_wp,
  input wire logic       drive0_select_n,
  input wire logic       drive1_select_n,
  input wire logic [7:0] core_pin_out,
  input wire logic [7:0] fdd_pin_o,
  input wire logic [7:0] fdd_pin_oe_n
);
  // Accepted strobes; data strobes count only while selected
  wire       rd_take = cfg_index_rd | (cfg_data_rd & cfg_ld_sel);
  wire       wr_take = cfg_data_wr & cfg_ld_sel;
  wire [3:0] mode_bits = {enhanced_mode, burst_dma_en, push_pull_driver,
                          pins_tristated};

  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);

  rvalid_on_read_a: assert property (rd_take |=> cfg_rvalid)
    else $error("no read answer one cycle after a read");
  rvalid_single_a: assert property (!rd_take |=> !cfg_rvalid)
    else $error("read answer without a read");
  mode_hold_a: assert property (!wr_take |=> $stable(mode_bits))
    else $error("mode outputs moved without a write");
  reset_mode_a: assert property ($rose(resetn) |-> mode_bits == 4'h0)
    else $error("mode outputs not at default after reset");
  wp_external_a: assert property ((!write_protect_in_n || dev_disable_wp)
    |-> status_reg_a_wp && !write_protect_core_n)
    else $error("write protect term lost");
  wp_quiet_a: assert property ((write_protect_in_n && !dev_disable_wp &&
    drive0_select_n && drive1_select_n) |-> !status_reg_a_wp)
    else $error("write protect without cause");
  pins_tristate_a: assert property (pins_tristated |->
    fdd_pin_oe_n == 8'hff)
    else $error("pins driven while tristated");
  pins_pushpull_a: assert property ((push_pull_driver && !pins_tristated)
    |-> fdd_pin_oe_n == 8'h00 && fdd_pin_o == core_pin_out)
    else $error("push-pull pins wrong");
  pins_opendrain_a: assert property ((!push_pull_driver && !pins_tristated)
    |-> fdd_pin_oe_n == core_pin_out && fdd_pin_o == 8'h00)
    else $error("open-drain pins wrong");
endmodule : fcr_cfg_assertions

// ===== test/test_floppy_config_regs.sv
// Self-checking bench for the floppy configuration bank.
// Assumes the bank and its checker are compiled before this file.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
  fail_count++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
  end end
module test_floppy_config_regs;
  logic clk, resetn, cfg_ld_sel, cfg_index_wr, cfg_index_rd;
  logic cfg_data_wr, cfg_data_rd, cfg_rvalid, enhanced_mode;
  logic burst_dma_en, push_pull_driver, pins_tristated;
  logic sel_precomp_disable, drive0_select_n, drive1_select_n;
  logic write_protect_in_n, dev_disable_wp, write_protect_core_n;
  logic status_reg_a_wp, density_core, density_out;
  logic [1:0] precomp_disable, sel_drive_type, sel_rate_table;
  logic [3:0] drive_type_bits, rate_table_bits;
  logic [7:0] core_pin_out, fdd_pin_o, fdd_pin_oe_n, v, m;
  fcr_pkg::fcr_byte_t  cfg_wdata, cfg_rdata, drive_type_store, exp_v;
  fcr_pkg::fcr_iface_e iface_mode;
  fcr_pkg::fcr_byte_t  exp_q[$], exp_s;
  int fail_count, total_checks, seed;

  fcr_floppy_config_regs u_dut (.*);

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // One index then data access; a read notes its expected byte
  task automatic acc(input logic [7:0] idx, input logic [7:0] d,
                     input logic r);
    @(posedge clk);
    cfg_index_wr <= 1'b1;
    cfg_wdata    <= idx;
    core_pin_out <= $random(seed);
    @(posedge clk);
    cfg_index_wr <= 1'b0;
    cfg_wdata    <= d;
    cfg_data_rd  <= r;
    cfg_data_wr  <= !r;
    if (r) exp_q.push_back(d);
    @(posedge clk);
    cfg_data_rd  <= 1'b0;
    cfg_data_wr  <= 1'b0;
  endtask : acc

  // Whole bank at its hard reset values
  task automatic dflt();
    acc(8'hf0, 8'h0e, 1'b1);
    acc(8'hf1, 8'h00, 1'b1);
    acc(8'hf2, 8'hff, 1'b1);
    acc(8'hf3, 8'h00, 1'b1);
    acc(8'hf4, 8'h00, 1'b1);
    acc(8'hf5, 8'h00, 1'b1);
    `CHK("iface_mode", 2'h3, iface_mode)
  endtask : dflt

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test

  // Read answers are matched in order against the noted bytes
  always @(negedge clk) begin
    if (cfg_rvalid === 1'b1) begin
      exp_v = (exp_q.size() != 0) ? exp_q.pop_front() : 8'hxx;
      `CHK("cfg_rdata", exp_v, cfg_rdata)
    end
  end

  initial begin
    seed = 91160;
    {cfg_ld_sel, cfg_index_wr, cfg_index_rd, cfg_data_wr} = 4'h0;
    {cfg_data_rd, density_core, dev_disable_wp, resetn} = 4'h0;
    {drive0_select_n, drive1_select_n, write_protect_in_n} = 3'h7;
    cfg_wdata = 8'h00;
    core_pin_out = 8'h00;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    cfg_ld_sel <= 1'b1;
    dflt();
    // Mode fields, every interface code, pins tri-stated and driven
    for (int i = 0; i < 8; i++) begin
      v = $random(seed);
      v[3:2] = i[1:0];
      v[7] = i[2];
      acc(8'hf0, v, 1'b0);
      @(negedge clk);
      `CHK("enhanced_mode", v[0], enhanced_mode)
      `CHK("burst_dma_en", !v[1], burst_dma_en)
      `CHK("iface_mode", v[3:2], iface_mode)
      `CHK("fdd_pin_o", v[6] ? core_pin_out : 8'h00, fdd_pin_o)
      `CHK("fdd_pin_oe_n", v[7] ? 8'hff : (v[6] ? 8'h00 : core_pin_out),
           fdd_pin_oe_n)
      acc(8'hf0, v & 8'hcf, 1'b1);
    end
    // Drive registers, type storage and the read-only slot
    for (int i = 0; i < 4; i++) begin
      v = $random(seed);
      m = $random(seed);
      acc(8'hf4, v, 1'b0);
      acc(8'hf5, m, 1'b0);
      acc(8'hf2, v ^ m, 1'b0);
      acc(8'hf3, m, 1'b0);
      acc(8'hf2, v ^ m, 1'b1);
      acc(8'hf3, 8'h00, 1'b1);
      acc(8'hf4, v & 8'h5b, 1'b1);
      acc(8'hf5, m & 8'h5b, 1'b1);
      `CHK("drive_type_bits", {m[1:0], v[1:0]}, drive_type_bits)
      `CHK("rate_table_bits", {m[4:3], v[4:3]}, rate_table_bits)
      `CHK("precomp_disable", {m[6], v[6]}, precomp_disable)
      `CHK("drive_type_store", v ^ m, drive_type_store)
      // Walk the select pair; only drive 1 alone picks its own fields
      @(posedge clk);
      {drive0_select_n, drive1_select_n} <= i[1:0];
      @(negedge clk);
      exp_s = (i[1:0] == 2'h2) ? m : v;
      `CHK("sel_drive_type", exp_s[1:0], sel_drive_type)
      `CHK("sel_rate_table", exp_s[4:3], sel_rate_table)
      `CHK("sel_precomp_disable", exp_s[6], sel_precomp_disable)
    end
    // Option codes against every select and protect input mix
    for (int j = 0; j < 8; j++) begin
      m = {4'h0, j[2:1], 1'b0, j[0]};
      acc(8'hf1, m | 8'hf2, 1'b0);
      acc(8'hf1, m, 1'b1);
      for (int i = 0; i < 32; i++) begin
        @(posedge clk);
        {density_core, drive0_select_n, drive1_select_n, write_protect_in_n,
         dev_disable_wp} <= i[4:0];
        @(negedge clk);
        v[0] = (m[0] & (!drive0_select_n | !drive1_select_n)) |
               !write_protect_in_n | dev_disable_wp;
        v[1] = (m[3:2] == 2'h2) | (!m[3] & density_core);
        `CHK("status_reg_a_wp", v[0], status_reg_a_wp)
        `CHK("write_protect_core_n", !v[0], write_protect_core_n)
        `CHK("density_out", v[1], density_out)
      end
    end
    // Data writes while deselected are dropped; index reads back
    acc(8'hf2, 8'h3c, 1'b0);
    @(posedge clk);
    cfg_ld_sel <= 1'b0;
    acc(8'hf2, 8'hc3, 1'b0);
    // A deselected data read must get no answer at all
    @(posedge clk);
    cfg_data_rd <= 1'b1;
    @(posedge clk);
    cfg_data_rd <= 1'b0;
    cfg_ld_sel  <= 1'b1;
    acc(8'hf2, 8'h3c, 1'b1);
    @(posedge clk);
    cfg_index_rd <= 1'b1;
    exp_q.push_back(8'hf2);
    @(posedge clk);
    cfg_index_rd <= 1'b0;
    // Hard reset in mid-run restores every default
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    dflt();
    for (int i = 0; i < 10 && exp_q.size() != 0; i++) @(negedge clk);
    if (exp_q.size() != 0) fail_count++;
    stop_test();
  end
endmodule : test_floppy_config_regs

bind fcr_floppy_config_regs fcr_cfg_assertions u_chk (.*);
